//--- src/li_ion_charge_sequencer.sv
// Behaviour
// - Below low threshold, start preconditioning with pre-charge current.
// - Dead state uses dead current, low state low current.
// - At low threshold enter fast charge current.
// - At regulation voltage switch to constant voltage.
// - Below finish current, run finish timer, then done.
// - Enter thermal limiting at programmed die threshold.
// - Thermal: double prequal and fast timers, halve CC current, lower CV voltage.
// - Status register shows thermal limiting bit.
// - Locked registers write only with lock key.
// - Dead stage compares battery against 1.9 V.
// - Dead timer expiry flags a shorted battery.
// - Unmasked dead fault raises interrupt, disables charging.
// - Attach detection: sink test, then source test.
// - Prequal safety timer ends charging on expiry.
// - Fast safety timer ends charging on expiry.
// - Done: recharge after 50 ms below margin.
// - Supply plug, attach or enable start new cycle.
// - Short flag below 0.8 V, released with hysteresis.
// - Reset monitor records most recent reset cause.
// - Soft reset restores defaults and clears itself.
// - Flag registers clear only bits written one.
`timescale 1ns/1ps
`default_nettype none
module li_ion_charge_sequencer #(
  parameter int TICK_CYCLES = lics_pkg::TICK_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       supplyValid,
  input  wire logic       batAttached,
  input  wire logic       batAboveDetLow,
  input  wire logic       batBelowDetUp,
  input  wire logic       batBelowLowThr,
  input  wire logic       batAtRegVolt,
  input  wire logic       chgBelowFinish,
  input  wire logic       batBelowRecharge,
  input  wire logic       batShortTrip,
  input  wire logic       batShortRelease,
  input  wire logic       dieAtThermalLimit,
  output logic            chargeEnable,
  output logic      [5:0] chargeCurrentCode,
  output logic            voltageMode,
  output logic      [5:0] voltageCode,
  output logic            detectSink,
  output logic            detectSource,
  output logic      [2:0] thermalLimitSel,
  output logic            rechargeMarginSel,
  output logic            deadFaultIrq
);
  localparam int NPIN = 11;

  // Comparator inputs are asynchronous to the clock.
  typedef struct packed {
    lics_pkg::lics_state_t state;
    logic [NPIN-1:0] sync1;      // First synchroniser stage.
    logic [NPIN-1:0] sync2;      // Second stage, the only one logic reads.
    logic            supplyPrev; // For the plug-in edge.
    logic            attachPrev; // For the attach edge.
    logic [15:0]     tickCnt;    // Millisecond prescaler.
    logic            tick;       // One-cycle millisecond strobe.
    logic            shortFlag;  // Battery pin short.
    logic            thermal;    // Thermal limiting active.
    logic            absent;     // Attach detection found no battery.
    logic            deadShort;  // Dead timer ran out.
    logic            deadEvent;  // Pulse toward the flag register.
    logic [5:0]      curCode;    // Current code to the analog loop.
    logic [5:0]      voltCode;   // Voltage code to the analog loop.
    logic            chargeOn;   // Charge path enabled.
    logic            cvMode;     // Voltage loop in control.
  } lics_core_t;

  lics_core_t       s_reg;
  lics_core_t       s_next;
  logic [1:0]       rstSync;
  logic             rstN;
  logic [NPIN-1:0]  pins;
  logic [3:0]       tmrRun;
  logic [3:0][26:0] tmrLimit;
  logic [3:0]       tmrDone;
  logic             rechargeDone;
  logic             startCycle;
  logic [2:0]       stateCode;
  logic [26:0]      preqBase;
  logic [26:0]      fastBase;

  lics_cfg_if cfg ();

  // Reset asserts asynchronously but is released on the clock.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  assign pins = {dieAtThermalLimit, batShortRelease, batShortTrip,
                 batBelowRecharge, chgBelowFinish, batAtRegVolt,
                 batBelowLowThr, batBelowDetUp, batAboveDetLow,
                 batAttached, supplyValid};

  // Prequal and fast safety limits double while the die is held at its thermal limit.
  assign preqBase    = lics_pkg::PREQ_MS[cfg.timerSel[5:4]];
  assign fastBase    = lics_pkg::FAST_MS[cfg.timerSel[3:2]];
  assign tmrLimit[0] = lics_pkg::DEAD_MS[cfg.timerSel[7:6]];
  assign tmrLimit[1] = s_reg.thermal ? {preqBase[25:0], 1'b0}
                                     : preqBase;
  assign tmrLimit[2] = s_reg.thermal ? {fastBase[25:0], 1'b0}
                                     : fastBase;
  assign tmrLimit[3] = lics_pkg::FINISH_MS[cfg.timerSel[1:0]];

  assign tmrRun[0] = (s_reg.state == lics_pkg::ST_DEAD);
  assign tmrRun[1] = (s_reg.state == lics_pkg::ST_DEAD) ||
                     (s_reg.state == lics_pkg::ST_PRE);
  assign tmrRun[2] = (s_reg.state == lics_pkg::ST_CC) ||
                     (s_reg.state == lics_pkg::ST_CV);
  assign tmrRun[3] = (s_reg.state == lics_pkg::ST_FINISH);

  // Dead, prequal, fast and finish timers share one structure.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_tmr
      lics_timer u_tmr (
        .clock   (clock),
        .rstN    (rstN),
        .tick    (s_reg.tick),
        .run     (tmrRun[g]),
        .limit   (tmrLimit[g]),
        .expired (tmrDone[g])
      );
    end
  endgenerate

  // Recharge deglitch: the below-recharge comparator must stay high for the whole window.
  lics_timer u_recharge (
    .clock   (clock),
    .rstN    (rstN),
    .tick    (s_reg.tick),
    .run     ((s_reg.state == lics_pkg::ST_DONE) && s_reg.sync2[7]),
    .limit   (lics_pkg::RECHARGE_DGL_MS),
    .expired (rechargeDone)
  );

  lics_reg_file u_regs (
    .clock        (clock),
    .rstN         (rstN),
    .regWrite     (regWrite),
    .regRead      (regRead),
    .regAddr      (regAddr),
    .regWdata     (regWdata),
    .regRdata     (regRdata),
    .deadFaultIrq (deadFaultIrq),
    .cfg          (cfg.regs)
  );

  // A fresh cycle needs a valid supply and one of the three start events.
  assign startCycle = s_reg.sync2[0] &&
                      ((!s_reg.supplyPrev) ||
                       (s_reg.sync2[1] && !s_reg.attachPrev) ||
                       cfg.chgEnPulse);

  // Binary state code for software.
  always_comb begin
    case (s_reg.state)
      lics_pkg::ST_DEAD:   stateCode = lics_pkg::CODE_DEAD;
      lics_pkg::ST_PRE:    stateCode = lics_pkg::CODE_PRE;
      lics_pkg::ST_CC:     stateCode = lics_pkg::CODE_CC;
      lics_pkg::ST_CV:     stateCode = lics_pkg::CODE_CV;
      lics_pkg::ST_FINISH: stateCode = lics_pkg::CODE_FINISH;
      lics_pkg::ST_DONE:   stateCode = lics_pkg::CODE_DONE;
      lics_pkg::ST_DET_SINK,
      lics_pkg::ST_DET_SOURCE: stateCode = lics_pkg::CODE_DETECT;
      default:             stateCode = lics_pkg::CODE_DISABLED;
    endcase
  end

  assign cfg.status    = {1'b0, s_reg.deadShort, s_reg.absent,
                          s_reg.shortFlag, s_reg.thermal,
                          stateCode};
  assign cfg.deadEvent = s_reg.deadEvent;

  // Sequencer, prescaler, flags and analog codes.
  always_comb begin
    s_next            = s_reg;
    s_next.sync1      = pins;
    s_next.sync2      = s_reg.sync1;
    s_next.supplyPrev = s_reg.sync2[0];
    s_next.attachPrev = s_reg.sync2[1];
    s_next.deadEvent  = 1'b0;
    s_next.tick       = 1'b0;
    if (s_reg.tickCnt == 16'(TICK_CYCLES - 1)) begin
      s_next.tickCnt = 16'h0000;
      s_next.tick    = 1'b1;
    end else begin
      s_next.tickCnt = s_reg.tickCnt + 16'h0001;
    end
    s_next.thermal = s_reg.sync2[10];
    // Separate trip and release comparators give the 80 mV hysteresis.
    if (s_reg.sync2[8]) begin
      s_next.shortFlag = 1'b1;
    end else if (s_reg.sync2[9]) begin
      s_next.shortFlag = 1'b0;
    end
    case (s_reg.state)
      lics_pkg::ST_DISABLED: begin
        // Faults park the sequencer here until a start event.
      end
      lics_pkg::ST_DET_SINK: begin
        // Wait one tick for the comparator to settle under the sink.
        if (s_reg.tick) begin
          if (s_reg.sync2[2]) begin
            s_next.state = lics_pkg::ST_DEAD;
          end else begin
            s_next.state = lics_pkg::ST_DET_SOURCE;
          end
        end
      end
      lics_pkg::ST_DET_SOURCE: begin
        if (s_reg.tick) begin
          if (s_reg.sync2[3]) begin
            s_next.state = lics_pkg::ST_DEAD;
          end else begin
            s_next.absent = 1'b1;
            s_next.state  = lics_pkg::ST_DISABLED;
          end
        end
      end
      lics_pkg::ST_DEAD: begin
        if (s_reg.sync2[2]) begin
          s_next.state = lics_pkg::ST_PRE;
        end else if (tmrDone[0]) begin
          s_next.deadShort = 1'b1;
          s_next.deadEvent = 1'b1;
          // Masked: carry on; unmasked: stop and let software decide.
          s_next.state = cfg.deadMask ? lics_pkg::ST_PRE
                                      : lics_pkg::ST_DISABLED;
        end else if (tmrDone[1]) begin
          s_next.state = lics_pkg::ST_DISABLED;
        end
      end
      lics_pkg::ST_PRE: begin
        if (tmrDone[1]) begin
          s_next.state = lics_pkg::ST_DISABLED;
        end else if (!s_reg.sync2[4]) begin
          s_next.state = lics_pkg::ST_CC;
        end
      end
      lics_pkg::ST_CC: begin
        if (tmrDone[2]) begin
          s_next.state = lics_pkg::ST_DISABLED;
        end else if (s_reg.sync2[5]) begin
          s_next.state = lics_pkg::ST_CV;
        end
      end
      lics_pkg::ST_CV: begin
        if (tmrDone[2]) begin
          s_next.state = lics_pkg::ST_DISABLED;
        end else if (s_reg.sync2[6]) begin
          s_next.state = lics_pkg::ST_FINISH;
        end
      end
      lics_pkg::ST_FINISH: begin
        if (tmrDone[3]) begin
          s_next.state = lics_pkg::ST_DONE;
        end
      end
      lics_pkg::ST_DONE: begin
        if (rechargeDone) begin
          s_next.state = lics_pkg::ST_CC;
        end
      end
      default: begin
        s_next.state = lics_pkg::ST_DISABLED;
      end
    endcase
    // A short on a charged battery ends charging; dead, sink-test and source-test states are exempt.
    if (s_reg.shortFlag && s_reg.state != lics_pkg::ST_DEAD &&
        s_reg.state != lics_pkg::ST_DET_SINK &&
        s_reg.state != lics_pkg::ST_DET_SOURCE) begin
      s_next.state = lics_pkg::ST_DISABLED;
    end
    if (!s_reg.sync2[0]) begin
      s_next.state = lics_pkg::ST_DISABLED;
    end
    if (startCycle) begin
      s_next.state     = lics_pkg::ST_DET_SINK;
      s_next.absent    = 1'b0;
      s_next.deadShort = 1'b0;
    end
    // Analog codes follow the state being entered.
    s_next.chargeOn = 1'b1;
    s_next.cvMode   = 1'b0;
    s_next.voltCode = cfg.regVolt;
    case (s_next.state)
      lics_pkg::ST_DEAD:   s_next.curCode = cfg.deadCur;
      lics_pkg::ST_PRE:    s_next.curCode = cfg.lowCur;
      lics_pkg::ST_CC: begin
        // Halving a code is a coarse step, but the 5 mA floor must hold.
        if (s_reg.thermal && cfg.fastCur != lics_pkg::CUR_5MA_CODE) begin
          s_next.curCode = {1'b0, cfg.fastCur[5:1]};
        end else begin
          s_next.curCode = cfg.fastCur;
        end
      end
      lics_pkg::ST_CV, lics_pkg::ST_FINISH: begin
        s_next.curCode = cfg.fastCur;
        s_next.cvMode  = 1'b1;
        if (s_reg.thermal) begin
          s_next.voltCode = (cfg.regVolt > lics_pkg::CV_THERMAL_DROP) ?
            cfg.regVolt - lics_pkg::CV_THERMAL_DROP : 6'h00;
        end
      end
      default: begin
        s_next.curCode  = 6'h00;
        s_next.chargeOn = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg       <= '0;
      s_reg.state <= lics_pkg::ST_DISABLED;
    end else begin
      s_reg <= s_next;
    end
  end

  assign chargeEnable      = s_reg.chargeOn;
  assign chargeCurrentCode = s_reg.curCode;
  assign voltageMode       = s_reg.cvMode;
  assign voltageCode       = s_reg.voltCode;
  assign detectSink        = (s_reg.state == lics_pkg::ST_DET_SINK);
  assign detectSource      = (s_reg.state == lics_pkg::ST_DET_SOURCE);
  assign thermalLimitSel   = cfg.thermalSel;
  assign rechargeMarginSel = cfg.marginSel;
endmodule
`default_nettype wire

//--- src/lics_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Configuration from the register file to the charger core, status back.
interface lics_cfg_if;
  logic [5:0] fastCur;      // Fast-charge current code.
  logic [5:0] deadCur;      // Dead-battery current code.
  logic [5:0] lowCur;       // Pre-charge current code.
  logic [5:0] finishCur;    // Finish threshold code.
  logic [5:0] regVolt;      // Regulation voltage code.
  logic [7:0] timerSel;     // Dead, prequal, fast and finish selects.
  logic       marginSel;    // Recharge margin select.
  logic [2:0] thermalSel;   // Thermal limit select.
  logic       deadMask;     // Dead fault mask, high means masked.
  logic       chgEnPulse;   // Charge enable written to one.
  logic [7:0] status;       // Live charger status.
  logic       deadEvent;    // Dead timer expired, one cycle.
  modport regs (output fastCur, deadCur, lowCur, finishCur, regVolt,
                output timerSel, marginSel, thermalSel, deadMask,
                output chgEnPulse, input status, deadEvent);
  modport core (input fastCur, deadCur, lowCur, finishCur, regVolt,
                input timerSel, marginSel, thermalSel, deadMask,
                input chgEnPulse, output status, deadEvent);
endinterface
`default_nettype wire

//--- src/lics_pkg.sv
package lics_pkg;

  // Register addresses on the internal register port.
  localparam logic [7:0] ADDR_INT1       = 8'h04;
  localparam logic [7:0] ADDR_INT1_MASK  = 8'h05;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h09;
  localparam logic [7:0] ADDR_CTL0       = 8'h10;
  localparam logic [7:0] ADDR_CTL7       = 8'h17;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_RESET_MON  = 8'h71;

  // Reset values and field positions.
  localparam logic [7:0] INT1_MASK_RST = 8'h7F;
  localparam int         DEAD_BIT      = 6;
  localparam logic [4:0] LOCK_KEY      = 5'h15;
  localparam int         CHG_EN_BIT    = 5;
  localparam int         SOFT_RST_BIT  = 0;
  localparam logic [7:0] MON_POWER_ON  = 8'h01;
  localparam logic [7:0] MON_SOFT      = 8'h02;
  // Control registers 0x10..0x17; only the first has a non-zero default.
  localparam logic [7:0][7:0] CTL_RST = {56'h0, 8'h20};

  // Millisecond tick derived from the 50 MHz clock.
  localparam int TICK_TIME_NS  = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Timer limits, counted in millisecond ticks.
  localparam int TMR_W = 27;
  localparam logic [3:0][26:0] DEAD_MS =
    {27'h0009C40, 27'h0004E20, 27'h0002710, 27'h0001388};
  localparam logic [3:0][26:0] PREQ_MS =
    {27'h036EE80, 27'h02932E0, 27'h01B7740, 27'h00DBBA0};
  localparam logic [3:0][26:0] FAST_MS =
    {27'h1EE6280, 27'h1808580, 27'h112A880, 27'h0A4CB80};
  localparam logic [3:0][26:0] FINISH_MS =
    {27'h0124F80, 27'h00927C0, 27'h00493E0, 27'h000EA60};
  localparam logic [26:0] RECHARGE_DGL_MS = 27'h0000032;

  // Current code of the 5 mA setting and the voltage step taken off in CV.
  localparam logic [5:0] CUR_5MA_CODE   = 6'h00;
  localparam logic [5:0] CV_THERMAL_DROP = 6'h02;

  // Binary charger state codes seen by software.
  localparam logic [2:0] CODE_DEAD     = 3'h0;
  localparam logic [2:0] CODE_PRE      = 3'h1;
  localparam logic [2:0] CODE_CC       = 3'h2;
  localparam logic [2:0] CODE_CV       = 3'h3;
  localparam logic [2:0] CODE_FINISH   = 3'h4;
  localparam logic [2:0] CODE_DONE     = 3'h5;
  localparam logic [2:0] CODE_DISABLED = 3'h6;
  localparam logic [2:0] CODE_DETECT   = 3'h7;

  typedef enum logic [3:0] {
    ST_DISABLED, ST_DET_SINK, ST_DET_SOURCE, ST_DEAD, ST_PRE,
    ST_CC, ST_CV, ST_FINISH, ST_DONE
  } lics_state_t;

endpackage

//--- src/lics_reg_file.sv
`timescale 1ns/1ps
`default_nettype none
// Charger registers: lock, write-to-clear flags, soft reset, reset cause.
module lics_reg_file (
  input  wire logic       clock,
  input  wire logic       rstN,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            deadFaultIrq,
  lics_cfg_if.regs        cfg
);
  typedef struct packed {
    logic [7:0]      int1;     // Sub-level flags, write one to clear.
    logic [7:0]      mask;     // Sub-level mask.
    logic [7:0][7:0] ctl;      // Control registers 0x10..0x17.
    logic [7:0]      mon;      // Reset cause.
    logic [7:0]      rdata;    // Read data.
    logic            enPulse;  // Charge enable written to one.
  } lics_regs_t;

  lics_regs_t s_reg;
  lics_regs_t s_next;
  logic [2:0] idx;
  logic       unlocked;

  assign idx      = regAddr[2:0];
  assign unlocked = (s_reg.ctl[0][4:0] == lics_pkg::LOCK_KEY);

  // Write decode, flag update and read mux.
  always_comb begin
    s_next         = s_reg;
    s_next.enPulse = 1'b0;
    // A clear aimed at a flag that sets in the same cycle loses.
    if (regWrite && regAddr == lics_pkg::ADDR_INT1) begin
      s_next.int1 = s_reg.int1 & ~regWdata;
    end
    if (cfg.deadEvent) begin
      s_next.int1[lics_pkg::DEAD_BIT] = 1'b1;
    end
    if (regWrite) begin
      if (regAddr == lics_pkg::ADDR_SOFT_RESET &&
          regWdata[lics_pkg::SOFT_RST_BIT]) begin
        // Flags, mask and controls return to default, the cause reads soft; the trigger bit is never stored.
        s_next.int1 = '0;
        s_next.mask = lics_pkg::INT1_MASK_RST;
        s_next.ctl  = lics_pkg::CTL_RST;
        s_next.mon  = lics_pkg::MON_SOFT;
      end else if (regAddr == lics_pkg::ADDR_INT1_MASK) begin
        s_next.mask = regWdata;
      end else if (regAddr == lics_pkg::ADDR_CTL0) begin
        // The lock register itself is always writable.
        s_next.ctl[0]  = regWdata;
        s_next.enPulse = regWdata[lics_pkg::CHG_EN_BIT];
      end else if (regAddr > lics_pkg::ADDR_CTL0 &&
                   regAddr <= lics_pkg::ADDR_CTL7 && unlocked) begin
        s_next.ctl[idx] = regWdata;
      end
    end
    if (regRead) begin
      if (regAddr == lics_pkg::ADDR_INT1) begin
        s_next.rdata = s_reg.int1;
      end else if (regAddr == lics_pkg::ADDR_INT1_MASK) begin
        s_next.rdata = s_reg.mask;
      end else if (regAddr >= lics_pkg::ADDR_CTL0 &&
                   regAddr <= lics_pkg::ADDR_CTL7) begin
        s_next.rdata = s_reg.ctl[idx];
      end else if (regAddr == lics_pkg::ADDR_STATUS) begin
        s_next.rdata = cfg.status;
      end else if (regAddr == lics_pkg::ADDR_RESET_MON) begin
        s_next.rdata = s_reg.mon;
      end else begin
        s_next.rdata = 8'h00;
      end
    end
  end

  // State register; power-on reset records its own cause.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg       <= '0;
      s_reg.mask  <= lics_pkg::INT1_MASK_RST;
      s_reg.ctl   <= lics_pkg::CTL_RST;
      s_reg.mon   <= lics_pkg::MON_POWER_ON;
    end else begin
      s_reg <= s_next;
    end
  end

  assign regRdata       = s_reg.rdata;
  assign deadFaultIrq   = s_reg.int1[lics_pkg::DEAD_BIT] &
                          ~s_reg.mask[lics_pkg::DEAD_BIT];
  assign cfg.fastCur    = s_reg.ctl[1][5:0];
  assign cfg.deadCur    = s_reg.ctl[2][5:0];
  assign cfg.lowCur     = s_reg.ctl[3][5:0];
  assign cfg.timerSel   = s_reg.ctl[4];
  assign cfg.regVolt    = s_reg.ctl[5][5:0];
  assign cfg.marginSel  = s_reg.ctl[5][6];
  assign cfg.finishCur  = s_reg.ctl[6][5:0];
  assign cfg.thermalSel = s_reg.ctl[7][2:0];
  assign cfg.deadMask   = s_reg.mask[lics_pkg::DEAD_BIT];
  assign cfg.chgEnPulse = s_reg.enPulse;
endmodule
`default_nettype wire

//--- src/lics_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Millisecond timer: counts ticks while run is high, clears when it drops.
module lics_timer (
  input  wire logic        clock,
  input  wire logic        rstN,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [26:0] limit,
  output logic             expired
);
  typedef struct packed {
    logic [26:0] count;   // Elapsed ticks.
    logic        done;    // Limit reached.
  } lics_tmr_t;

  lics_tmr_t s_reg;
  lics_tmr_t s_next;

  // Expiry sticks until run falls, so a slow state change cannot miss it.
  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next = '0;
    end else if (tick && !s_reg.done) begin
      s_next.count = s_reg.count + 27'h0000001;
      s_next.done  = (s_next.count >= limit);
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.done;
endmodule
`default_nettype wire

//--- verif/li_ion_charge_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module li_ion_charge_sequencer_test;
  logic       clock = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0;
  logic       input_supply = 1'h0;  // Input supply present.
  logic       hot = 1'h0;  // Die at its thermal limit.
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q;
  logic       chg, cv, snk, src, msel, irq;
  logic [2:0] tsel;
  logic [5:0] cur, volt;
  int         mv, bad_count = 0, tests_run = 0, cyc = 0;
  lics_battery bat (.clock, .charging(chg), .holdVolt(cv), .sinkOn(snk),
    .sourceOn(src), .pinMv(mv));
  // One millisecond is one cycle here, so the finish minute fits the run.
  li_ion_charge_sequencer #(.TICK_CYCLES(1)) DUT (.clock, .resetn,
    .regWrite(wr), .regRead(rd), .regAddr(addr), .regWdata(wdata),
    .regRdata(rdata), .supplyValid(input_supply), .batAttached(bat.present),
    .batAboveDetLow(mv > 1900), .batBelowDetUp(mv < 3400),
    .batBelowLowThr(mv < 3000), .batAtRegVolt(mv >= 4200),
    .chgBelowFinish(cv), .batBelowRecharge(mv < 4060),
    .batShortTrip(mv < 800), .batShortRelease(mv > 880),
    .dieAtThermalLimit(hot), .chargeEnable(chg), .chargeCurrentCode(cur),
    .voltageMode(cv), .voltageCode(volt), .detectSink(snk),
    .detectSource(src), .thermalLimitSel(tsel), .rechargeMarginSel(msel),
    .deadFaultIrq(irq));
  initial forever #10 clock = ~clock;
  // The ceiling covers the finish minute with room to spare.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Each access leaves an idle edge so a strobe never toggles twice at once.
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(posedge clock) #1 wr = 1'h0;
    @(posedge clock) #1;
  endtask
  task automatic rreg(logic [7:0] a);
    addr = a;
    rd = 1'h1;
    @(posedge clock) #1 rd = 1'h0;
    q = rdata;
    @(posedge clock) #1;
  endtask
  task automatic rc(string name, logic [7:0] a, logic [7:0] exp);
    rreg(a);
    check(name, q, exp);
  endtask
  // Polls the state field; the bound covers the longest phase.
  task automatic wait_state(logic [2:0] c);
    q = 'x;
    for (int i = 0; i < 35000 && q[2:0] !== c; i++) rreg(8'h18);
    check("state", {5'h00, q[2:0]}, {5'h00, c});
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1 resetn = 1'h1;
    repeat (3) @(posedge clock);
    #1;
    rc("mask", 8'h05, 8'h7F);
    wreg(8'h05, 8'h7F);
    rc("cause", 8'h71, 8'h01);
    rc("unmapped", 8'h30, 8'h00);
    wreg(8'h11, 8'h2A);
    rc("locked", 8'h11, 8'h00);
    wreg(8'h10, 8'h35);
    wreg(8'h11, 8'h2A);
    wreg(8'h13, 8'h0C);
    wreg(8'h15, 8'h70);
    wreg(8'h17, 8'h05);
    rc("unlocked", 8'h11, 8'h2A);
    check("margin", {7'h00, msel}, 8'h01);
    check("limit", {5'h00, tsel}, 8'h05);
    input_supply = 1'h1;
    wait_state(lics_pkg::CODE_PRE);
    check("pre cur", {2'h0, cur}, 8'h0C);
    wait_state(lics_pkg::CODE_CC);
    check("cc cur", {2'h0, cur}, 8'h2A);
    hot = 1'h1;
    // Two sync stages plus the flag register: the third read sees it.
    rreg(8'h18);
    rreg(8'h18);
    rreg(8'h18);
    check("thermal", q & 8'h08, 8'h08);
    check("half cur", {2'h0, cur}, 8'h15);
    hot = 1'h0;
    wait_state(lics_pkg::CODE_FINISH);
    check("cv", {1'h0, cv, volt}, 8'h70);
    wait_state(lics_pkg::CODE_DONE);
    bat.cellMv = 3900;
    wait_state(lics_pkg::CODE_CC);
    bat.cellMv = 500;
    wait_state(lics_pkg::CODE_DISABLED);
    check("short", q & 8'h10, 8'h10);
    wreg(8'h09, 8'h01);
    rc("cause", 8'h71, 8'h02);
    rc("cleared", 8'h11, 8'h00);
    rc("self clear", 8'h09, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

//--- verif/lics_battery.sv
`timescale 1ns/1ps
`default_nettype none
// Cell model giving the pin voltage in mV.
module lics_battery (
  input  wire logic clock,
  input  wire logic charging,
  input  wire logic holdVolt,
  input  wire logic sinkOn,
  input  wire logic sourceOn,
  output var  int   pinMv
);
  int cellMv = 2500;  // Set by the bench between phases.
  bit present = 1'h1; // An absent cell leaves the pin to the test current.
  assign pinMv = present ? cellMv : (sourceOn && !sinkOn ? 5000 : 0);
  // A slow rise keeps every phase long enough to be polled.
  always @(posedge clock)
    if (charging && !holdVolt && cellMv < 4200) cellMv <= cellMv + 1;
endmodule
`default_nettype wire

//--- verif/lics_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks. Read data lands one edge after the read strobe.
module lics_props (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       supplyValid,
  input wire logic       chargeEnable,
  input wire logic       detectSink,
  input wire logic       detectSource,
  input wire logic [2:0] thermalLimitSel,
  input wire logic       rechargeMarginSel,
  input wire logic       deadFaultIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_tests_exclusive:
    assert property (!(detectSink && detectSource)) else $error("Overlap.");
  a_no_supply_off:
    assert property (!supplyValid [*6] |-> !chargeEnable) else $error("Sup.");
  a_unmapped_zero:
    assert property (regRead && regAddr inside {[8'h20:8'h70]} |=>
      regRdata == 8'h00) else $error("Unmapped.");
  a_cause_code:
    assert property (regRead && regAddr == lics_pkg::ADDR_RESET_MON |=>
      regRdata inside {8'h01, 8'h02}) else $error("Cause.");
  a_soft_reads_zero:
    assert property (regRead && regAddr == lics_pkg::ADDR_SOFT_RESET |=>
      regRdata == 8'h00) else $error("Soft bit.");
  a_read_holds:
    assert property (!regRead |=> $stable(regRdata)) else $error("Rdata.");
  a_margin_steady:
    assert property (!regWrite |=> $stable(rechargeMarginSel))
      else $error("Margin.");
  a_limit_steady:
    assert property (!regWrite |=> $stable(thermalLimitSel))
      else $error("Limit.");
  a_mask_gates_irq:
    assert property (regWrite && regAddr == lics_pkg::ADDR_INT1_MASK &&
      regWdata[6] |=> !deadFaultIrq) else $error("Irq.");
  c_start: cover property ($rose(chargeEnable));
  c_sink: cover property (detectSink);
  c_soft: cover property (regWrite && regAddr == lics_pkg::ADDR_SOFT_RESET);
endmodule
bind li_ion_charge_sequencer lics_props u_props (.clock, .resetn,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .supplyValid,
  .chargeEnable, .detectSink, .detectSource, .thermalLimitSel,
  .rechargeMarginSel, .deadFaultIrq);
`default_nettype wire
